// File: rtl/wss_pkg.sv
package wss_pkg;

  // clock and timing
  localparam int unsigned WSS_CLK_HZ = 125_000_000;
  localparam int unsigned WSS_BACKSTEP_HOLD_MS = 1500;
  localparam int unsigned WSS_HOLD_CYCLES =
    WSS_BACKSTEP_HOLD_MS * (WSS_CLK_HZ / 1000);
  localparam int unsigned WSS_EDIT_MSG_MS = 1000;
  localparam int unsigned WSS_MSG_CYCLES =
    WSS_EDIT_MSG_MS * (WSS_CLK_HZ / 1000);

  // schedule space
  localparam int unsigned WSS_SCHED_W = 7;
  localparam logic [6:0] WSS_SCHED_LAST = 7'h63;
  localparam int unsigned WSS_SKIP_N = 8;

  // register byte offsets
  localparam logic [4:0] WSS_OFS_CTRL = 5'h00;
  localparam logic [4:0] WSS_OFS_SEQ_TIME = 5'h04;
  localparam logic [4:0] WSS_OFS_PIN = 5'h08;
  localparam logic [4:0] WSS_OFS_SCHED_CFG = 5'h0c;
  localparam logic [4:0] WSS_OFS_STATUS = 5'h10;
  localparam logic [4:0] WSS_OFS_SCHED_SEL = 5'h14;

  // control register fields
  localparam int unsigned WSS_CTRL_EXT_SEL = 0;
  localparam int unsigned WSS_CTRL_LOCK_MAP = 1;
  localparam int unsigned WSS_CTRL_SKIP_MAP = 2;
  localparam int unsigned WSS_CTRL_W = 3;

  // sequence time fields: length low half, squeeze high half
  localparam int unsigned WSS_SEQ_LEN_LSB = 0;
  localparam int unsigned WSS_SEQ_SQZ_LSB = 16;

  // schedule config fields
  localparam int unsigned WSS_CFG_MODE_LSB = 0;
  localparam int unsigned WSS_CFG_CTR_LSB = 2;
  localparam int unsigned WSS_CFG_IDX_LSB = 8;

  // status fields
  localparam int unsigned WSS_STS_SEL_LSB = 0;
  localparam int unsigned WSS_STS_FIRST_LSB = 8;
  localparam int unsigned WSS_STS_FLASH = 16;
  localparam int unsigned WSS_STS_LOCKED = 17;
  localparam int unsigned WSS_STS_UNLOCKED = 18;
  localparam int unsigned WSS_STS_RUN = 19;
  localparam int unsigned WSS_STS_SKIP_LSB = 20;

  // reset values
  localparam logic [2:0] WSS_CTRL_RST = 3'h0;
  localparam logic [31:0] WSS_SEQ_TIME_RST = 32'h0004_0010;
  localparam logic [15:0] WSS_PIN_RST = 16'h0000;

  // schedule cycle modes
  localparam logic [1:0] WSS_MODE_NONREP = 2'h0;
  localparam logic [1:0] WSS_MODE_SUCC = 2'h1;
  localparam logic [1:0] WSS_MODE_CHAIN = 2'h2;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] contactor;
  } wss_sched_t;

  typedef struct packed {
    logic menu_req;
    logic menu_exit;
    logic pin_valid;
    logic [15:0] pin_value;
    logic edit_req;
  } wss_pend_req_t;

  typedef enum logic [1:0] {
    WSS_SEQ_READY = 2'b01,
    WSS_SEQ_RUN = 2'b10
  } wss_seq_st_t;

  typedef enum logic [2:0] {
    WSS_UI_STATUS = 3'b001,
    WSS_UI_PIN = 3'b010,
    WSS_UI_MENU = 3'b100
  } wss_ui_st_t;

endpackage

// File: rtl/wss_sync.sv
`timescale 1ns/1ps
`default_nettype none
module wss_sync #(
  parameter int unsigned W = 1
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/wss_top.sv
// Notes on behaviour
// - successive schedule runs full non-repeat sequence
// - after successive schedule, advance number, go ready
// - advanced number flashes, next initiation starts it
// - after non-repeat last schedule, back to first
// - external select starts and returns series there
// - momentary step-back selects previous schedule
// - step-back never passes first schedule of series
// - step-back held 1.5 s returns to first
// - skip only when inputs mapped to skip functions
// - closed skip input skips schedule, lights indicator
// - edit lock shows steady lock marker
// - locked menu request shows pin entry page
// - correct pin unlocks pendant edits
// - wrong pin allows menu viewing, rejects edits
// - barred edit blocked, edits-disabled message shown
// - lockout key acts only when mapped to lock
// - no-weld runs all steps without current
// - external mode takes number from select inputs
`timescale 1ns/1ps
`default_nettype none
module wss_top
  import wss_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = WSS_HOLD_CYCLES,
  parameter int unsigned MSG_CYCLES = WSS_MSG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic initiate_input,
  input wire logic step_back_input,
  input wire logic lockout_key_input,
  input wire logic weld_enable_input,
  input wire logic [WSS_SKIP_N-1:0] contactor_skip_input,
  input wire logic [WSS_SCHED_W-1:0] schedule_select_inputs,
  input wire wss_pend_req_t pend_req,
  output logic weld_current_q,
  output logic seq_active_q,
  output logic [WSS_SCHED_W-1:0] sched_num_q,
  output logic sched_flash_q,
  output logic [WSS_SKIP_N-1:0] skip_led_q,
  output logic lock_indicator_q,
  output logic pin_page_q,
  output logic menu_open_q,
  output logic edit_accept_q,
  output logic edits_disabled_q
);

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pins are asynchronous to ref_clk
  localparam int unsigned SW = 4 + WSS_SKIP_N + WSS_SCHED_W;
  logic [SW-1:0] pins_sync;
  wss_sync #(.W(SW)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({initiate_input, step_back_input, lockout_key_input,
               weld_enable_input, contactor_skip_input,
               schedule_select_inputs}),
    .sync_out(pins_sync)
  );

  wire init_s = pins_sync[SW-1];
  wire back_s = pins_sync[SW-2];
  wire key_s = pins_sync[SW-3];
  wire weld_en_s = pins_sync[SW-4];
  wire [WSS_SKIP_N-1:0] skip_s = pins_sync[WSS_SCHED_W +: WSS_SKIP_N];
  wire [WSS_SCHED_W-1:0] ext_sel_s = pins_sync[WSS_SCHED_W-1:0];

  // register file
  logic [WSS_CTRL_W-1:0] ctrl_q;
  logic [31:0] seq_time_q;
  logic [15:0] pin_q;
  logic [WSS_SCHED_W-1:0] cfg_idx_q;
  wss_sched_t sched_mem [0:(1<<WSS_SCHED_W)-1];

  wire acc = avs_read | avs_write;
  wire wr_go = avs_write & ~avs_waitrequest;
  wire wr_ctrl = wr_go & (avs_address == WSS_OFS_CTRL);
  wire wr_seq = wr_go & (avs_address == WSS_OFS_SEQ_TIME);
  wire wr_pin = wr_go & (avs_address == WSS_OFS_PIN);
  wire wr_cfg = wr_go & (avs_address == WSS_OFS_SCHED_CFG);
  wire wr_sel = wr_go & (avs_address == WSS_OFS_SCHED_SEL);
  wire [31:0] wd_ctrl = be_merge({29'h0, ctrl_q}, avs_writedata,
                                 avs_byteenable);
  wire [31:0] wd_seq = be_merge(seq_time_q, avs_writedata, avs_byteenable);
  wire [31:0] wd_pin = be_merge({16'h0, pin_q}, avs_writedata,
                                avs_byteenable);

  wire ext_mode = ctrl_q[WSS_CTRL_EXT_SEL];
  wire [15:0] seq_len = seq_time_q[WSS_SEQ_LEN_LSB +: 16];
  wire [15:0] seq_sqz = seq_time_q[WSS_SEQ_SQZ_LSB +: 16];

  // lock decode
  wire locked = ctrl_q[WSS_CTRL_LOCK_MAP] & key_s;
  logic unlocked_q;
  wire can_edit = ~locked | unlocked_q;
  wire [WSS_SKIP_N-1:0] skip_act =
    ctrl_q[WSS_CTRL_SKIP_MAP] ? skip_s : '0;

  // stepper state
  wss_seq_st_t seq_st_q;
  logic [15:0] seq_cnt_q;
  logic [WSS_SCHED_W-1:0] first_q;
  logic init_prev_q;
  logic back_prev_q;
  logic back_timing_q;
  logic [27:0] back_cnt_q;

  wss_sched_t cur;
  assign cur = sched_mem[sched_num_q];
  wire in_ready = (seq_st_q == WSS_SEQ_READY);
  wire init_rise = init_s & ~init_prev_q;
  wire start = in_ready & init_rise;
  wire skipped = skip_act[cur.contactor];
  wire run_end = (seq_st_q == WSS_SEQ_RUN) &
                 ((seq_len == 16'h0) | (seq_cnt_q == seq_len - 16'h1));
  wire finish = (start & skipped) | run_end;
  // outputs follow the next state so the last programmed step is kept
  wire run_next = (start & ~skipped) |
                  ((seq_st_q == WSS_SEQ_RUN) & ~run_end);
  wire [15:0] cnt_next = in_ready ? 16'h0 : seq_cnt_q + 16'h1;
  wire is_succ = (cur.mode == WSS_MODE_SUCC);
  wire [WSS_SCHED_W-1:0] series_home = ext_mode ? ext_sel_s : first_q;
  wire [WSS_SCHED_W-1:0] sel_plus =
    (sched_num_q == WSS_SCHED_LAST) ? first_q : sched_num_q + 7'h1;
  wire [WSS_SCHED_W-1:0] sel_minus = sched_num_q - 7'h1;

  wire back_rise = back_s & ~back_prev_q;
  wire back_hold_hit = back_timing_q & back_s &
                       (back_cnt_q == 28'(HOLD_CYCLES - 1));
  wire back_short = back_timing_q & ~back_s;
  wire above_first = sched_num_q != first_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_prev_q <= 1'b0;
      back_prev_q <= 1'b0;
    end else begin
      init_prev_q <= init_s;
      back_prev_q <= back_s;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      seq_st_q <= WSS_SEQ_READY;
      seq_cnt_q <= 16'h0;
    end else begin
      unique case (seq_st_q)
        WSS_SEQ_READY: begin
          seq_cnt_q <= 16'h0;
          if (start & ~skipped) begin
            seq_st_q <= WSS_SEQ_RUN;
          end
        end
        WSS_SEQ_RUN: begin
          seq_cnt_q <= seq_cnt_q + 16'h1;
          if (run_end) begin
            seq_st_q <= WSS_SEQ_READY;
          end
        end
      endcase
    end
  end

  // back-step timer runs only while the switch stays closed
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      back_timing_q <= 1'b0;
      back_cnt_q <= 28'h0;
    end else if (back_rise) begin
      back_timing_q <= 1'b1;
      back_cnt_q <= 28'h0;
    end else if (back_short | back_hold_hit) begin
      back_timing_q <= 1'b0;
    end else if (back_timing_q) begin
      back_cnt_q <= back_cnt_q + 28'h1;
    end
  end

  // selection: finish beats back-step, back-step beats software select
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sched_num_q <= 7'h0;
      first_q <= 7'h0;
      sched_flash_q <= 1'b0;
    end else if (finish) begin
      if (is_succ) begin
        sched_num_q <= sel_plus;
        sched_flash_q <= 1'b1;
      end else begin
        sched_num_q <= series_home;
        sched_flash_q <= 1'b0;
      end
    end else if (start) begin
      if (~sched_flash_q) begin
        first_q <= sched_num_q;
      end
    end else if (in_ready & back_hold_hit) begin
      sched_num_q <= first_q;
      sched_flash_q <= 1'b0;
    end else if (in_ready & back_short & above_first) begin
      sched_num_q <= sel_minus;
      sched_flash_q <= (sel_minus != first_q);
    end else if (in_ready & ~sched_flash_q & ext_mode) begin
      sched_num_q <= ext_sel_s;
      first_q <= ext_sel_s;
    end else if (in_ready & ~sched_flash_q & wr_sel) begin
      sched_num_q <= avs_writedata[WSS_SCHED_W-1:0];
      first_q <= avs_writedata[WSS_SCHED_W-1:0];
    end
  end

  // weld outputs
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      weld_current_q <= 1'b0;
      seq_active_q <= 1'b0;
      skip_led_q <= '0;
    end else begin
      seq_active_q <= run_next;
      // no current without the enable input, steps still run
      weld_current_q <= run_next & (cnt_next >= seq_sqz) & weld_en_s;
      skip_led_q <= skip_act;
    end
  end

  // pendant front end
  wss_ui_st_t ui_st_q;
  logic [31:0] msg_cnt_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ui_st_q <= WSS_UI_STATUS;
      unlocked_q <= 1'b0;
      edit_accept_q <= 1'b0;
    end else begin
      edit_accept_q <= 1'b0;
      if (~locked) begin
        unlocked_q <= 1'b0;
      end
      unique case (ui_st_q)
        WSS_UI_STATUS: begin
          if (pend_req.menu_req) begin
            ui_st_q <= (locked & ~unlocked_q) ? WSS_UI_PIN
                                              : WSS_UI_MENU;
          end
        end
        WSS_UI_PIN: begin
          if (pend_req.pin_valid) begin
            // wrong pin still opens the menu for viewing
            unlocked_q <= locked & (pend_req.pin_value == pin_q);
            ui_st_q <= WSS_UI_MENU;
          end
        end
        WSS_UI_MENU: begin
          if (pend_req.menu_exit) begin
            ui_st_q <= WSS_UI_STATUS;
            unlocked_q <= 1'b0;
          end else if (pend_req.edit_req) begin
            edit_accept_q <= can_edit;
          end
        end
        default: ui_st_q <= WSS_UI_STATUS;
      endcase
    end
  end

  wire edit_blocked = (ui_st_q == WSS_UI_MENU) & ~pend_req.menu_exit &
                      pend_req.edit_req & ~can_edit;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      msg_cnt_q <= 32'h0;
      edits_disabled_q <= 1'b0;
      lock_indicator_q <= 1'b0;
      pin_page_q <= 1'b0;
      menu_open_q <= 1'b0;
    end else begin
      if (edit_blocked) begin
        msg_cnt_q <= MSG_CYCLES;
      end else if (msg_cnt_q != 32'h0) begin
        msg_cnt_q <= msg_cnt_q - 32'h1;
      end
      edits_disabled_q <= edit_blocked | (msg_cnt_q > 32'h1);
      lock_indicator_q <= locked;
      pin_page_q <= (ui_st_q == WSS_UI_PIN);
      menu_open_q <= (ui_st_q == WSS_UI_MENU);
    end
  end

  // avalon slave: one wait state, then the access completes
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= WSS_CTRL_RST;
      seq_time_q <= WSS_SEQ_TIME_RST;
      pin_q <= WSS_PIN_RST;
      cfg_idx_q <= 7'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= wd_ctrl[WSS_CTRL_W-1:0];
      end
      if (wr_seq) begin
        seq_time_q <= wd_seq;
      end
      if (wr_pin) begin
        pin_q <= wd_pin[15:0];
      end
      if (wr_cfg) begin
        cfg_idx_q <= avs_writedata[WSS_CFG_IDX_LSB +: WSS_SCHED_W];
      end
    end
  end

  // schedule table has no reset; software loads it before use
  always_ff @(posedge ref_clk) begin
    if (wr_cfg) begin
      sched_mem[avs_writedata[WSS_CFG_IDX_LSB +: WSS_SCHED_W]] <=
        {avs_writedata[WSS_CFG_MODE_LSB +: 2],
         avs_writedata[WSS_CFG_CTR_LSB +: 3]};
    end
  end

  wss_sched_t cfg_rd;
  assign cfg_rd = sched_mem[cfg_idx_q];
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      WSS_OFS_CTRL: rd_mux = {29'h0, ctrl_q};
      WSS_OFS_SEQ_TIME: rd_mux = seq_time_q;
      WSS_OFS_PIN: rd_mux = 32'h0;
      WSS_OFS_SCHED_CFG: rd_mux = {17'h0, cfg_idx_q, 3'h0,
                                   cfg_rd.contactor, cfg_rd.mode};
      WSS_OFS_STATUS: rd_mux = {4'h0, skip_act,
                                (seq_st_q == WSS_SEQ_RUN), unlocked_q,
                                locked, sched_flash_q, 1'b0, first_q,
                                1'b0, sched_num_q};
      WSS_OFS_SCHED_SEL: rd_mux = {25'h0, sched_num_q};
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~(acc & avs_waitrequest);
      if (avs_read & avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// File: test/wss_chk.sv
`timescale 1ns/1ps
`default_nettype none
module wss_chk
  import wss_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic weld_enable_input,
  input wire logic [WSS_SKIP_N-1:0] contactor_skip_input,
  input wire wss_pend_req_t pend_req,
  input wire logic weld_current_q,
  input wire logic seq_active_q,
  input wire logic [WSS_SCHED_W-1:0] sched_num_q,
  input wire logic [WSS_SKIP_N-1:0] skip_led_q,
  input wire logic lock_indicator_q,
  input wire logic pin_page_q,
  input wire logic menu_open_q,
  input wire logic edit_accept_q,
  input wire logic edits_disabled_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  bus_answer_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  no_weld_a: assert property (
    (!weld_enable_input)[*5] |=> !weld_current_q)
    else $error("current while weld enable open");
  current_in_seq_a: assert property (
    weld_current_q |-> seq_active_q)
    else $error("current outside sequence");
  sel_hold_a: assert property (
    seq_active_q && $past(seq_active_q) |-> $stable(sched_num_q))
    else $error("schedule moved mid run");
  skip_idle_a: assert property (
    (contactor_skip_input == '0)[*4] |=> skip_led_q == '0)
    else $error("skip light with inputs open");
  pin_gate_a: assert property (
    pend_req.menu_req && lock_indicator_q && !menu_open_q && !pin_page_q
    |-> ##2 (pin_page_q && !menu_open_q))
    else $error("locked menu skipped pin page");
  edit_answer_a: assert property (
    pend_req.edit_req && menu_open_q
    |=> ##[0:1] (edit_accept_q || edits_disabled_q))
    else $error("edit got no answer");
  page_excl_a: assert property (
    !(pin_page_q && menu_open_q))
    else $error("pin page and menu together");
endmodule
bind wss_top wss_chk chk_u (.ref_clk, .sys_rst, .avs_read, .avs_write,
  .avs_waitrequest, .weld_enable_input, .contactor_skip_input, .pend_req,
  .weld_current_q, .seq_active_q, .sched_num_q, .skip_led_q,
  .lock_indicator_q, .pin_page_q, .menu_open_q, .edit_accept_q,
  .edits_disabled_q);
`default_nettype wire

// File: test/wss_panel.sv
`timescale 1ns/1ps
`default_nettype none
module wss_panel
  import wss_pkg::*;
(
  input wire logic ref_clk,
  output logic initiate_input,
  output logic step_back_input,
  output logic lockout_key_input,
  output logic weld_enable_input,
  output logic [WSS_SKIP_N-1:0] contactor_skip_input,
  output logic [WSS_SCHED_W-1:0] schedule_select_inputs
);
  initial begin
    initiate_input = 1'b0;
    step_back_input = 1'b0;
    lockout_key_input = 1'b0;
    weld_enable_input = 1'b1;
    contactor_skip_input = 8'h00;
    schedule_select_inputs = 7'h00;
  end
  // held a few cycles so the two-flop sync sees a clean closure
  task automatic press(input int n);
    @(posedge ref_clk);
    initiate_input <= 1'b1;
    repeat (n) @(posedge ref_clk);
    initiate_input <= 1'b0;
  endtask
  task automatic back(input int n);
    @(posedge ref_clk);
    step_back_input <= 1'b1;
    repeat (n) @(posedge ref_clk);
    step_back_input <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/tb_weld_schedule_stepper.sv
`timescale 1ns/1ps
`default_nettype none
module tb_weld_schedule_stepper
  import wss_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, weld_current_q, seq_active_q, sched_flash_q;
  logic lock_indicator_q, pin_page_q, menu_open_q, edit_accept_q;
  logic edits_disabled_q;
  logic [6:0] sched_num_q;
  logic [7:0] skip_led_q;
  wss_pend_req_t pend_req = '0;
  wire logic initiate_input, step_back_input, lockout_key_input;
  wire logic weld_enable_input;
  wire logic [7:0] contactor_skip_input;
  wire logic [6:0] schedule_select_inputs;
  int bad_count = 0;
  int cmp_count = 0;
  int act, cur;
  initial forever #4 ref_clk = ~ref_clk;
  wss_top #(.HOLD_CYCLES(20), .MSG_CYCLES(5)) dut_u (.ref_clk, .sys_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
    .initiate_input, .step_back_input, .lockout_key_input,
    .weld_enable_input, .contactor_skip_input, .schedule_select_inputs,
    .pend_req, .weld_current_q, .seq_active_q, .sched_num_q,
    .sched_flash_q, .skip_led_q, .lock_indicator_q, .pin_page_q,
    .menu_open_q, .edit_accept_q, .edits_disabled_q);
  wss_panel panel_u (.ref_clk, .initiate_input, .step_back_input,
    .lockout_key_input, .weld_enable_input, .contactor_skip_input,
    .schedule_select_inputs);
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20) begin
      bad_count++;
      complete_run;
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e,
    input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // a fixed window catches both a missing run and an unwanted restart
  task automatic run(input int ea, input int ec, input logic [6:0] es,
    input logic ef);
    act = 0;
    cur = 0;
    panel_u.press(3);
    repeat (40) begin
      @(posedge ref_clk);
      act += int'(seq_active_q === 1'b1);
      cur += int'(weld_current_q === 1'b1);
    end
    #1;
    chk("active cycles", ea, act);
    chk("current cycles", ec, cur);
    chk("schedule", {25'h0, es}, {25'h0, sched_num_q});
    chk("flash", {31'h0, ef}, {31'h0, sched_flash_q});
  endtask
  task automatic back(input int n, input logic [6:0] es);
    panel_u.back(n);
    wait_n(6);
    chk("schedule", {25'h0, es}, {25'h0, sched_num_q});
  endtask
  task automatic pend(input logic [19:0] p);
    @(posedge ref_clk);
    pend_req <= p;
    @(posedge ref_clk);
    pend_req <= '0;
    act = 0;
    repeat (2) begin
      #1;
      act += int'(edit_accept_q === 1'b1);
      @(posedge ref_clk);
    end
    #1;
  endtask
  task automatic t_regs;
    int i;
    logic [1:0] m;
    rd(WSS_OFS_CTRL, 32'h0, "ctrl reset");
    rd(WSS_OFS_SEQ_TIME, WSS_SEQ_TIME_RST, "seq time reset");
    bus(1'b1, WSS_OFS_PIN, 32'h0000_1234);
    rd(WSS_OFS_PIN, 32'h0, "pin readback");
    bus(1'b1, 5'h18, 32'hffff_ffff);
    rd(5'h18, 32'h0, "unmapped");
    bus(1'b1, WSS_OFS_SEQ_TIME, 32'h0002_0008);
    rd(WSS_OFS_SEQ_TIME, 32'h0002_0008, "seq time");
    for (i = 0; i < 5; i++) begin
      m = (i == 1 || i == 2) ? WSS_MODE_SUCC : WSS_MODE_NONREP;
      bus(1'b1, WSS_OFS_SCHED_CFG, {17'h0, i[6:0], 3'h0, i[2:0], m});
    end
    rd(WSS_OFS_SCHED_CFG, {17'h0, 7'h04, 6'h04, WSS_MODE_NONREP}, "cfg");
    bus(1'b1, WSS_OFS_SCHED_SEL, 32'h1);
    rd(WSS_OFS_SCHED_SEL, 32'h1, "sched sel");
  endtask
  task automatic t_succ;
    run(8, 6, 7'h02, 1'b1);
    run(8, 6, 7'h03, 1'b1);
    run(8, 6, 7'h01, 1'b0);
  endtask
  task automatic t_back;
    run(8, 6, 7'h02, 1'b1);
    run(8, 6, 7'h03, 1'b1);
    back(30, 7'h01);
    run(8, 6, 7'h02, 1'b1);
    back(3, 7'h01);
    back(3, 7'h01);
    chk("flash", 32'h0, {31'h0, sched_flash_q});
  endtask
  task automatic t_noweld;
    panel_u.weld_enable_input <= 1'b0;
    run(8, 0, 7'h02, 1'b1);
    panel_u.weld_enable_input <= 1'b1;
    back(3, 7'h01);
  endtask
  task automatic t_skip;
    panel_u.contactor_skip_input <= 8'h02;
    run(8, 6, 7'h02, 1'b1);
    chk("skip led", 32'h0, {24'h0, skip_led_q});
    back(3, 7'h01);
    bus(1'b1, WSS_OFS_CTRL, 32'h4);
    run(0, 0, 7'h02, 1'b1);
    chk("skip led", 32'h2, {24'h0, skip_led_q});
    panel_u.contactor_skip_input <= 8'h00;
    back(3, 7'h01);
  endtask
  task automatic t_ext;
    panel_u.schedule_select_inputs <= 7'h02;
    bus(1'b1, WSS_OFS_CTRL, 32'h1);
    wait_n(6);
    chk("schedule", 32'h2, {25'h0, sched_num_q});
    run(8, 6, 7'h03, 1'b1);
    run(8, 6, 7'h02, 1'b0);
  endtask
  task automatic t_lock;
    bus(1'b1, WSS_OFS_CTRL, 32'h0);
    panel_u.lockout_key_input <= 1'b1;
    wait_n(6);
    chk("lock", 32'h0, {31'h0, lock_indicator_q});
    bus(1'b1, WSS_OFS_CTRL, 32'h2);
    wait_n(4);
    chk("lock", 32'h1, {31'h0, lock_indicator_q});
    pend(20'h80000);
    chk("pin page", 32'h1, {31'h0, pin_page_q});
    pend(20'h22222);
    chk("menu", 32'h1, {31'h0, menu_open_q});
    pend(20'h00001);
    chk("accept", 32'h0, act);
    chk("disabled", 32'h1, {31'h0, edits_disabled_q});
    pend(20'h40000);
    chk("disabled", 32'h0, {31'h0, edits_disabled_q});
    chk("menu", 32'h0, {31'h0, menu_open_q});
    pend(20'h80000);
    pend(20'h22468);
    pend(20'h00001);
    chk("accept", 32'h1, act);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_succ;
    t_back;
    t_noweld;
    t_skip;
    t_ext;
    t_lock;
    complete_run;
  end
endmodule
`default_nettype wire
